/* hdl/rtcs_map.vh */
// register offsets, field positions, reset values and timing for the rtc supervisor
// assumes a 125 MHz system clock
`ifndef RTCS_MAP_VH
`define RTCS_MAP_VH

`define RTCS_ADDR_CTRL      5'h08
`define RTCS_ADDR_WDOG      5'h09
`define RTCS_ADDR_ALARM_MONTH_AND_ENABLES  5'h0a
`define RTCS_ADDR_AL_DATE   5'h0b
`define RTCS_ADDR_AL_HOUR   5'h0c
`define RTCS_ADDR_AL_MIN    5'h0d
`define RTCS_ADDR_AL_SEC    5'h0e
`define RTCS_ADDR_FLAGS     5'h0f
`define RTCS_ADDR_SQW       5'h13

`define RTCS_CTRL_OUT_BIT   7
`define RTCS_CTRL_FT_BIT    6
`define RTCS_WD_STEER_BIT   7
`define RTCS_AM_AFE_BIT     7
`define RTCS_AM_SQUARE_WAVE_ENABLE_BIT    6
`define RTCS_AM_ABE_BIT     5
`define RTCS_RPT_BIT        7
`define RTCS_RPT5_BIT       6
`define RTCS_FLAG_WDF_BIT   7
`define RTCS_FLAG_AF_BIT    6
`define RTCS_FLAG_BL_BIT    4

`define RTCS_RST_BYTE       8'h00
`define RTCS_RST_CTRL       8'h80

`define RTCS_CLK_HZ         125000000
`define RTCS_CLK_MHZ        125
`define RTCS_OSC2_HZ        65536
`define RTCS_FT_TAP         6
`define RTCS_WD_TICK_BITS   12

`define RTCS_POST_POWER_HOLD_TIME_SHORT_US  1000
`define RTCS_POST_POWER_HOLD_TIME_MID_US    97000
`define RTCS_POST_POWER_HOLD_TIME_LONG_US   100000
`define RTCS_RESET_INPUT_ONE_MIN_NS  200
`define RTCS_RESET_INPUT_TWO_MIN_US  100000

`endif

/* hdl/rtcs_low_filter.v */
// low-level qualifier: reports a low only after it has lasted a set number of cycles
// assumes level_in is already synchronised to clk
`timescale 1ns/1ns
module rtcs_low_filter #(
	parameter [23:0] MIN_CYC = 24'd25
) (
	input  wire clk,
	input  wire srst,
	input  wire level_in,
	output reg  low_out_reg
);
	reg [23:0] cnt_reg;

	always @(posedge clk) begin
		if (srst) begin
			cnt_reg     <= 24'h00_0000;
			low_out_reg <= 1'b0;
		end else if (level_in) begin
			cnt_reg     <= 24'h00_0000;
			low_out_reg <= 1'b0;
		end else if (cnt_reg < MIN_CYC - 24'd1) begin
			cnt_reg <= cnt_reg + 24'd1;
		end else begin
			low_out_reg <= 1'b1;
		end
	end
endmodule // rtcs_low_filter

/* hdl/rtcs_supervisor.v */
// alarm, watchdog, square wave and reset supervisor of a serial rtc
// assumes the serial bus engine supplies register strobes, pointer and bcd time
// Functional notes
// [RULE1] alarm settings held; match sets alarm flag
// [RULE2] repeat bits pick second..year alarm period
// [RULE3] undefined repeat codes act as per-second
// [RULE4] enabled alarm match drives interrupt pin low
// [RULE5] host disables alarm by zeroing date, repeats
// [RULE6] pointer on flags defers alarm interrupt
// [RULE7] flags read releases pin; flag clears after
// [RULE8] on battery, alarm needs backup and irq enable
// [RULE9] power-up clears backup and irq enables
// [RULE10] watchdog multiplier times resolution sets timeout
// [RULE11] missed restart sets watchdog flag, acts
// [RULE12] steer bit picks interrupt or reset pulse
// [RULE13] reset timeout clears watchdog and enable bits
// [RULE14] kick edge or register write restarts watchdog
// [RULE15] writing zero releases pin, disables watchdog
// [RULE16] flags read clears watchdog flag
// [RULE17] power-up clears watchdog register
// [RULE18] watchdog interrupt overrides frequency test
// [RULE19] rate field selects square wave frequency
// [RULE20] power fail holds reset low, then hold
// [RULE21] qualified reset inputs act as power reset
// [RULE22] reset released after hold once inputs high
// [RULE23] hold time set by length, halt bits
// [RULE24] idle pin follows output level bit
// [RULE25] flags hold watchdog, alarm, battery low bits
// [RULE26] interrupt pin is open-drain active low
// [RULE27] square wave static when off
`timescale 1ns/1ns
`include "rtcs_map.vh"
module rtcs_supervisor #(
	parameter [23:0] HOLD_SHORT_CYC = `RTCS_POST_POWER_HOLD_TIME_SHORT_US * `RTCS_CLK_MHZ,
	parameter [23:0] HOLD_MID_CYC   = `RTCS_POST_POWER_HOLD_TIME_MID_US * `RTCS_CLK_MHZ,
	parameter [23:0] HOLD_LONG_CYC  = `RTCS_POST_POWER_HOLD_TIME_LONG_US * `RTCS_CLK_MHZ,
	parameter [23:0] RESET_INPUT_TWO_CYC     = `RTCS_RESET_INPUT_TWO_MIN_US * `RTCS_CLK_MHZ
) (
	input  wire       clk,
	input  wire       srst,
	input  wire [4:0] reg_addr,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire [4:0] reg_pointer,
	input  wire       time_update,
	input  wire [7:0] cur_sec,
	input  wire [7:0] cur_min,
	input  wire [7:0] cur_hour,
	input  wire [7:0] cur_date,
	input  wire [7:0] cur_month,
	input  wire       deselect_length_bit,
	input  wire       oscillator_halt_bit,
	input  wire       vcc_ok,
	input  wire       on_battery,
	input  wire       battery_low,
	input  wire       watchdog_kick_input,
	input  wire       reset_input_one,
	input  wire       reset_input_two,
	output reg        irq_pin_out,
	output reg        irq_pin_oe,
	output reg        rst_pin_out,
	output reg        rst_pin_oe,
	output reg        square_wave_output
);
	localparam [26:0] OSC_STEP = `RTCS_OSC2_HZ;
	localparam [26:0] OSC_MOD  = `RTCS_CLK_HZ;
	localparam [23:0] RESET_INPUT_ONE_CYC =
		(`RTCS_RESET_INPUT_ONE_MIN_NS * `RTCS_CLK_MHZ + 999) / 1000;

	reg [7:0]  ctrl_reg;
	reg [7:0]  wdog_reg;
	reg [7:0]  alarm_month_and_enables_reg;
	reg [7:0]  al_date_reg;
	reg [7:0]  al_hour_reg;
	reg [7:0]  al_min_reg;
	reg [7:0]  al_sec_reg;
	reg [7:0]  sqw_reg;
	reg        watchdog_flag_reg;
	reg        alarm_flag_reg;
	reg        alarm_pend_reg;
	reg        wd_irq_reg;
	reg [26:0] osc_acc_reg;
	reg        osc_tick_reg;
	reg [15:0] prescale_reg;
	reg [10:0] wd_cnt_reg;
	reg [23:0] hold_reg;
	reg [2:0]  kick_sync_reg;
	reg [1:0]  vcc_sync_reg;
	reg [1:0]  bat_sync_reg;
	reg [1:0]  bl_sync_reg;
	reg [1:0]  r1_sync_reg;
	reg [1:0]  r2_sync_reg;

	wire       r1_low;
	wire       r2_low;
	wire       flags_rd = reg_rd && (reg_addr == `RTCS_ADDR_FLAGS);
	wire       wd_wr    = reg_wr && (reg_addr == `RTCS_ADDR_WDOG);
	wire       wd_en    = (wdog_reg[6:2] != 5'h00);
	wire       wd_tick  = osc_tick_reg && (prescale_reg[`RTCS_WD_TICK_BITS-1:0] == 12'hfff);
	wire       kick     = kick_sync_reg[2] ^ kick_sync_reg[1];
	wire       wd_limit_hit;
	wire       wd_timeout = wd_en && wd_tick && !kick && !wd_wr && wd_limit_hit;
	wire       wd_rst_fire = wd_timeout && wdog_reg[`RTCS_WD_STEER_BIT];
	wire       alarm_hit;
	wire       afe  = alarm_month_and_enables_reg[`RTCS_AM_AFE_BIT];
	wire       abe  = alarm_month_and_enables_reg[`RTCS_AM_ABE_BIT];
	wire       square_wave_enable = alarm_month_and_enables_reg[`RTCS_AM_SQUARE_WAVE_ENABLE_BIT];
	wire       ft   = ctrl_reg[`RTCS_CTRL_FT_BIT];
	wire       rst_src = !vcc_sync_reg[1] || r1_low || r2_low || wd_rst_fire;

	// bcd alarm compare under the repeat-mode mask
	function match_fn;
		input [4:0] rpt;
		input [39:0] al;
		input [39:0] now;
		reg   [4:0] need;
		begin
			need = 5'b00000;
			case (rpt)
			5'b11111: need = 5'b00000;
			5'b11110: need = 5'b00001;
			5'b11100: need = 5'b00011;
			5'b11000: need = 5'b00111;
			5'b10000: need = 5'b01111;
			5'b00000: need = 5'b11111;
			default:  need = 5'b00000; // RULE3
			endcase
			match_fn = (!need[0] || al[6:0] == now[6:0]) &&
				(!need[1] || al[14:8] == now[14:8]) &&
				(!need[2] || al[21:16] == now[21:16]) &&
				(!need[3] || al[29:24] == now[29:24]) &&
				(!need[4] || al[36:32] == now[36:32]); // RULE2
		end
	endfunction

	// timeout in sixteenths of a second: multiplier scaled by 1, 4, 16 or 64
	function [10:0] wd_limit_fn;
		input [7:0] wd;
		begin
			wd_limit_fn = {6'h00, wd[6:2]} << {wd[1:0], 1'b0}; // RULE10
		end
	endfunction

	// prescaler tap for a rate code: code 1 is 32768 Hz, else 32768 >> code
	function [3:0] sqw_tap_fn;
		input [3:0] code;
		begin
			sqw_tap_fn = (code == 4'h1) ? 4'h0 : code; // RULE19
		end
	endfunction

	function [23:0] hold_fn;
		input tr;
		input st;
		begin
			if (tr)
				hold_fn = HOLD_SHORT_CYC;
			else if (st)
				hold_fn = HOLD_LONG_CYC;
			else
				hold_fn = HOLD_MID_CYC; // RULE23
		end
	endfunction

	assign wd_limit_hit = ({1'b0, wd_cnt_reg} + 12'd1) >= {1'b0, wd_limit_fn(wdog_reg)};
	assign alarm_hit = time_update && match_fn(
		{al_date_reg[`RTCS_RPT5_BIT], al_date_reg[`RTCS_RPT_BIT],
		al_hour_reg[`RTCS_RPT_BIT], al_min_reg[`RTCS_RPT_BIT], al_sec_reg[`RTCS_RPT_BIT]},
		{alarm_month_and_enables_reg, al_date_reg, al_hour_reg, al_min_reg, al_sec_reg},
		{cur_month, cur_date, cur_hour, cur_min, cur_sec}); // RULE1

	rtcs_low_filter #(
		.MIN_CYC (RESET_INPUT_ONE_CYC)
	) u_reset_input_one (
		.clk         (clk),
		.srst        (srst),
		.level_in    (r1_sync_reg[1]),
		.low_out_reg (r1_low)
	);

	rtcs_low_filter #(
		.MIN_CYC (RESET_INPUT_TWO_CYC)
	) u_reset_input_two (
		.clk         (clk),
		.srst        (srst),
		.level_in    (r2_sync_reg[1]),
		.low_out_reg (r2_low)
	);

	// pin synchronisers
	always @(posedge clk) begin
		if (srst) begin
			kick_sync_reg <= 3'b000;
			vcc_sync_reg  <= 2'b00;
			bat_sync_reg  <= 2'b00;
			bl_sync_reg   <= 2'b00;
			r1_sync_reg   <= 2'b11;
			r2_sync_reg   <= 2'b11;
		end else begin
			kick_sync_reg <= {kick_sync_reg[1:0], watchdog_kick_input};
			vcc_sync_reg  <= {vcc_sync_reg[0], vcc_ok};
			bat_sync_reg  <= {bat_sync_reg[0], on_battery};
			bl_sync_reg   <= {bl_sync_reg[0], battery_low};
			r1_sync_reg   <= {r1_sync_reg[0], reset_input_one};
			r2_sync_reg   <= {r2_sync_reg[0], reset_input_two};
		end
	end

	// 65536 Hz enable from the system clock, then the oscillator divider chain
	always @(posedge clk) begin
		if (srst) begin
			osc_acc_reg  <= 27'h000_0000;
			osc_tick_reg <= 1'b0;
			prescale_reg <= 16'h0000;
		end else begin
			if (osc_acc_reg + OSC_STEP >= OSC_MOD) begin
				osc_acc_reg  <= osc_acc_reg + OSC_STEP - OSC_MOD;
				osc_tick_reg <= 1'b1;
			end else begin
				osc_acc_reg  <= osc_acc_reg + OSC_STEP;
				osc_tick_reg <= 1'b0;
			end
			if (osc_tick_reg)
				prescale_reg <= prescale_reg + 16'h0001;
		end
	end

	// register file, flags and watchdog
	always @(posedge clk) begin
		if (srst) begin
			ctrl_reg          <= `RTCS_RST_CTRL;
			wdog_reg          <= `RTCS_RST_BYTE; // RULE17
			alarm_month_and_enables_reg      <= `RTCS_RST_BYTE; // RULE9
			al_date_reg       <= `RTCS_RST_BYTE;
			al_hour_reg       <= `RTCS_RST_BYTE;
			al_min_reg        <= `RTCS_RST_BYTE;
			al_sec_reg        <= `RTCS_RST_BYTE;
			sqw_reg           <= `RTCS_RST_BYTE;
			watchdog_flag_reg <= 1'b0;
			alarm_flag_reg    <= 1'b0;
			alarm_pend_reg    <= 1'b0;
			wd_irq_reg        <= 1'b0;
			wd_cnt_reg        <= 11'h000;
			reg_rdata         <= 8'h00;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				`RTCS_ADDR_CTRL:     ctrl_reg <= reg_wdata;
				`RTCS_ADDR_WDOG:     wdog_reg <= reg_wdata;
				`RTCS_ADDR_ALARM_MONTH_AND_ENABLES: alarm_month_and_enables_reg <= reg_wdata;
				`RTCS_ADDR_AL_DATE:  al_date_reg <= reg_wdata; // RULE5
				`RTCS_ADDR_AL_HOUR:  al_hour_reg <= reg_wdata;
				`RTCS_ADDR_AL_MIN:   al_min_reg <= reg_wdata;
				`RTCS_ADDR_AL_SEC:   al_sec_reg <= reg_wdata;
				`RTCS_ADDR_SQW:      sqw_reg <= {reg_wdata[7:4], 4'h0};
				default:             ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`RTCS_ADDR_CTRL:     reg_rdata <= ctrl_reg;
				`RTCS_ADDR_WDOG:     reg_rdata <= wdog_reg;
				`RTCS_ADDR_ALARM_MONTH_AND_ENABLES: reg_rdata <= alarm_month_and_enables_reg;
				`RTCS_ADDR_AL_DATE:  reg_rdata <= al_date_reg;
				`RTCS_ADDR_AL_HOUR:  reg_rdata <= al_hour_reg;
				`RTCS_ADDR_AL_MIN:   reg_rdata <= al_min_reg;
				`RTCS_ADDR_AL_SEC:   reg_rdata <= al_sec_reg;
				`RTCS_ADDR_FLAGS:    reg_rdata <= {watchdog_flag_reg, alarm_flag_reg, 1'b0,
					bl_sync_reg[1], 4'h0}; // RULE25
				`RTCS_ADDR_SQW:      reg_rdata <= sqw_reg;
				default:             reg_rdata <= 8'h00;
				endcase
			end
			// old flag value is returned, the clear shows on the next read
			if (alarm_hit)
				alarm_flag_reg <= 1'b1; // RULE1
			else if (flags_rd)
				alarm_flag_reg <= 1'b0; // RULE7
			if (alarm_hit && afe && (!bat_sync_reg[1] || abe))
				alarm_pend_reg <= 1'b1; // RULE8
			else if (flags_rd)
				alarm_pend_reg <= 1'b0; // RULE7
			if (wd_timeout)
				watchdog_flag_reg <= 1'b1; // RULE11
			else if (flags_rd)
				watchdog_flag_reg <= 1'b0; // RULE16
			if (wd_timeout && !wdog_reg[`RTCS_WD_STEER_BIT])
				wd_irq_reg <= 1'b1; // RULE12
			else if (wd_wr && reg_wdata == 8'h00)
				wd_irq_reg <= 1'b0; // RULE15
			if (!wd_en || kick || wd_wr)
				wd_cnt_reg <= 11'h000; // RULE14
			else if (wd_tick)
				wd_cnt_reg <= wd_limit_hit ? 11'h000 : wd_cnt_reg + 11'h001;
			if (wd_rst_fire) begin
				wdog_reg <= `RTCS_RST_BYTE; // RULE13
				ctrl_reg[`RTCS_CTRL_FT_BIT] <= 1'b0;
				alarm_month_and_enables_reg[`RTCS_AM_AFE_BIT]  <= 1'b0;
				alarm_month_and_enables_reg[`RTCS_AM_ABE_BIT]  <= 1'b0;
				alarm_month_and_enables_reg[`RTCS_AM_SQUARE_WAVE_ENABLE_BIT] <= 1'b0;
			end
		end
	end

	// reset output: held while any source stands, then for the hold time
	always @(posedge clk) begin
		if (srst) begin
			hold_reg    <= HOLD_LONG_CYC; // RULE20
			rst_pin_oe  <= 1'b1;
			rst_pin_out <= 1'b0;
		end else begin
			rst_pin_out <= 1'b0;
			if (rst_src)
				hold_reg <= hold_fn(deselect_length_bit, oscillator_halt_bit); // RULE21
			else if (hold_reg != 24'h00_0000)
				hold_reg <= hold_reg - 24'h00_0001; // RULE22
			rst_pin_oe <= rst_src || (hold_reg > 24'h00_0001);
		end
	end

	// shared interrupt / test / level pin
	always @(posedge clk) begin
		if (srst) begin
			irq_pin_oe         <= 1'b0;
			irq_pin_out        <= 1'b0;
			square_wave_output <= 1'b0;
		end else begin
			irq_pin_out <= 1'b0;
			if (wd_irq_reg || (alarm_pend_reg && reg_pointer != `RTCS_ADDR_FLAGS))
				irq_pin_oe <= 1'b1; // RULE26 RULE4 RULE6 RULE18
			else if (afe)
				irq_pin_oe <= 1'b0;
			else if (ft && !oscillator_halt_bit && (wdog_reg[`RTCS_WD_STEER_BIT] || !wd_en))
				irq_pin_oe <= !prescale_reg[`RTCS_FT_TAP];
			else if (!ft && wdog_reg == 8'h00)
				irq_pin_oe <= !ctrl_reg[`RTCS_CTRL_OUT_BIT]; // RULE24
			else
				irq_pin_oe <= 1'b0;
			if (!square_wave_enable || sqw_reg[7:4] == 4'h0)
				square_wave_output <= 1'b0; // RULE27
			else
				square_wave_output <= prescale_reg[sqw_tap_fn(sqw_reg[7:4])]; // RULE19
		end
	end
endmodule // rtcs_supervisor

/* tb/rtcs_supervisor_monitor.sv */
// checker for the rtc supervisor ports: pins, reset output, read data
// assumes binding to rtcs_supervisor, one clock domain
`timescale 1ns/1ns
module rtcs_supervisor_monitor (
	input wire       clk,
	input wire       srst,
	input wire [4:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       vcc_ok,
	input wire       reset_input_one,
	input wire       irq_pin_out,
	input wire       irq_pin_oe,
	input wire       rst_pin_out,
	input wire       rst_pin_oe
);
	reg [7:0] lo1_cnt_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// consecutive low cycles on reset input one
	always @(posedge clk) begin
		if (srst || reset_input_one)
			lo1_cnt_reg <= 8'h00;
		else if (lo1_cnt_reg != 8'hff)
			lo1_cnt_reg <= lo1_cnt_reg + 8'h01;
	end
	irq_open_drain_a: assert property (irq_pin_out == 1'b0)
		else $error("irq pin drives high");
	rst_open_drain_a: assert property (rst_pin_out == 1'b0)
		else $error("reset pin drives high");
	vcc_fail_rst_a: assert property (!vcc_ok [*5] |-> rst_pin_oe)
		else $error("reset output free while supply low");
	powerup_hold_a: assert property ($fell(srst) |-> rst_pin_oe [*8])
		else $error("reset output released too soon after power up");
	powerup_quiet_a: assert property ($fell(srst) |-> !irq_pin_oe [*8])
		else $error("irq pin pulled after power up");
	flags_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 5'h0f
		|-> reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0)
		else $error("flags unused bits not zero");
	rate_nibble_a: assert property ($past(reg_rd) && $past(reg_addr) == 5'h13
		|-> reg_rdata[3:0] == 4'h0)
		else $error("rate low nibble not zero");
	rstin_act_a: assert property (lo1_cnt_reg >= 8'd36 |-> rst_pin_oe)
		else $error("long reset input low gave no reset");
	rstin_hold_a: assert property ($rose(reset_input_one) && lo1_cnt_reg >= 8'd36
		|-> rst_pin_oe [*8])
		else $error("reset output not held after input release");
endmodule // rtcs_supervisor_monitor

bind rtcs_supervisor rtcs_supervisor_monitor i_rtcs_supervisor_monitor (
	.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.vcc_ok(vcc_ok), .reset_input_one(reset_input_one), .irq_pin_out(irq_pin_out),
	.irq_pin_oe(irq_pin_oe), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));

/* tb/rtcs_host.sv */
// host processor model: register strobes and watchdog kick pin
// assumes the supervisor takes strobes at rising clk, read data one cycle later
`timescale 1ns/1ns
module rtcs_host (
	input  wire       clk,
	input  wire [7:0] reg_rdata,
	output reg  [4:0] reg_addr = 5'h00,
	output reg        reg_wr = 1'b0,
	output reg        reg_rd = 1'b0,
	output reg  [7:0] reg_wdata = 8'h00,
	output reg        watchdog_kick_input = 1'b0
);
	task wr(input [4:0] a, input [7:0] v);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [4:0] a, output [7:0] v);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 v = reg_rdata;
		end
	endtask
	task kick;
		begin
			@(posedge clk);
			watchdog_kick_input <= ~watchdog_kick_input;
		end
	endtask
	task alarm_off;
		begin
			wr(5'h0b, 8'h00);
			wr(5'h0c, 8'h00);
			wr(5'h0d, 8'h00);
			wr(5'h0e, 8'h00);
		end
	endtask
endmodule // rtcs_host

/* tb/rtcs_supervisor_tb_top.sv */
// top testbench of the rtc supervisor with host model and bound checker
// assumes shortened hold parameters; watchdog timeouts too long to run
`timescale 1ns/1ns
module rtcs_supervisor_tb_top;
	localparam [39:0] ALARM = 40'h06_1510_2030;
	reg         clk = 1'b0;
	reg         srst = 1'b1;
	reg  [4:0]  reg_pointer = 5'h00;
	reg         time_update = 1'b0;
	reg  [39:0] now = 40'h00_0000_0000;
	reg         tr = 1'b0;
	reg         st = 1'b0;
	reg         bl = 1'b0;
	reg         vcc_ok = 1'b1;
	reg         on_battery = 1'b0;
	reg         rin1 = 1'b1;
	reg         rin2 = 1'b1;
	reg  [7:0]  d;
	wire [7:0]  rdata;
	wire [7:0]  wdata;
	wire [4:0]  addr;
	wire        wr, rd, kick, irq_out, irq_oe, rst_out, rst_oe, square_wave_rate;
	integer     miscompares = 0;
	integer     checked = 0;
	integer     cyc = 0;
	rtcs_host i_rtcs_host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wdata), .watchdog_kick_input(kick));
	rtcs_supervisor #(.HOLD_SHORT_CYC(24'd20), .HOLD_MID_CYC(24'd40), .HOLD_LONG_CYC(24'd50),
		.RESET_INPUT_TWO_CYC(24'd30)) i_rtcs_supervisor (.clk(clk), .srst(srst), .reg_addr(addr),
		.reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_pointer(reg_pointer),
		.time_update(time_update), .cur_sec(now[7:0]), .cur_min(now[15:8]),
		.cur_hour(now[23:16]), .cur_date(now[31:24]), .cur_month(now[39:32]),
		.deselect_length_bit(tr), .oscillator_halt_bit(st), .vcc_ok(vcc_ok),
		.on_battery(on_battery), .battery_low(bl), .watchdog_kick_input(kick),
		.reset_input_one(rin1), .reset_input_two(rin2), .irq_pin_out(irq_out),
		.irq_pin_oe(irq_oe), .rst_pin_out(rst_out), .rst_pin_oe(rst_oe),
		.square_wave_output(square_wave_rate));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		begin
			$display("checks %0d miscompares %0d", checked, miscompares);
			if (miscompares == 0 && checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [7:0] exp, input [7:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("wrong value %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task fire(input [39:0] t);
		begin
			@(posedge clk);
			now <= t;
			time_update <= 1'b1;
			@(posedge clk);
			time_update <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask
	task hit(input [4:0] c, input [39:0] t, input af);
		begin
			i_rtcs_host.wr(5'h0b, {c[3], c[4], 6'h15});
			i_rtcs_host.wr(5'h0c, {c[2], 7'h10});
			i_rtcs_host.wr(5'h0d, {c[1], 7'h20});
			i_rtcs_host.wr(5'h0e, {c[0], 7'h30});
			fire(t);
			#1 chk("irq", af, irq_oe);
			i_rtcs_host.rd(5'h0f, d);
			chk("alarm_flag", af, d[6]);
			@(posedge clk);
			#1 chk("irq_release", 0, irq_oe);
			i_rtcs_host.rd(5'h0f, d);
			chk("flag_cleared", 0, d[6]);
		end
	endtask
	task t_regs;
		integer i;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				i_rtcs_host.rd(5'h08 + {2'b00, i == 1, i == 2 || i == 5, i > 2}
					+ (i > 3 ? 5'h01 : 5'h00) + (i > 4 ? 5'h02 : 5'h00), d);
				chk("reset_value", i == 0 ? 8'h80 : 8'h00, d);
			end
			@(posedge clk) bl <= 1'b1;
			repeat (3) @(posedge clk);
			i_rtcs_host.rd(5'h0f, d);
			chk("battery_low", 8'h10, d);
			@(posedge clk) bl <= 1'b0;
			$display("test register reset values done");
		end
	endtask
	task t_modes;
		reg [34:0] codes;
		integer i;
		integer n;
		begin
			codes = {5'b11111, 5'b11110, 5'b11100, 5'b11000, 5'b10000, 5'b00000, 5'b01111};
			i_rtcs_host.wr(5'h0a, 8'h86);
			for (i = 0; i < 7; i = i + 1) begin
				n = i > 5 ? 0 : i;
				if (n > 0)
					hit(codes[34-5*i -: 5], ALARM ^ (40'h1 << (8 * (n - 1))), 0);
				// year mode: the shift runs out, exact alarm time
				hit(codes[34-5*i -: 5], ALARM ^ (40'h1 << (8 * n)), 1);
			end
			$display("test alarm repeat modes done");
		end
	endtask
	task t_defer_batt;
		begin
			@(posedge clk) reg_pointer <= 5'h0f;
			fire(ALARM);
			#1 chk("irq_deferred", 0, irq_oe);
			@(posedge clk) reg_pointer <= 5'h00;
			repeat (4) @(posedge clk);
			#1 chk("irq_after_move", 1, irq_oe);
			i_rtcs_host.rd(5'h0f, d);
			@(posedge clk) on_battery <= 1'b1;
			repeat (4) @(posedge clk);
			fire(ALARM);
			#1 chk("irq_batt_off", 0, irq_oe);
			i_rtcs_host.rd(5'h0f, d);
			chk("af_batt", 1, d[6]);
			i_rtcs_host.wr(5'h0a, 8'ha6);
			fire(ALARM);
			#1 chk("irq_batt_on", 1, irq_oe);
			i_rtcs_host.rd(5'h0f, d);
			@(posedge clk) on_battery <= 1'b0;
			i_rtcs_host.alarm_off;
			$display("test pointer and backup done");
		end
	endtask
	task t_wdog_sqw;
		integer i;
		integer n;
		begin
			i_rtcs_host.wr(5'h09, 8'h0e);
			i_rtcs_host.kick;
			i_rtcs_host.rd(5'h09, d);
			chk("watchdog_reg", 8'h0e, d);
			i_rtcs_host.wr(5'h09, 8'h00);
			i_rtcs_host.rd(5'h09, d);
			chk("watchdog_off", 8'h00, d);
			i_rtcs_host.wr(5'h13, 8'h1f);
			i_rtcs_host.rd(5'h13, d);
			chk("rate_reg", 8'h10, d);
			i_rtcs_host.wr(5'h0a, 8'h46);
			n = 0;
			for (i = 0; i < 7630; i = i + 1) begin
				@(posedge clk);
				#1 if (square_wave_rate !== d[0])
					n = n + 1;
				d[0] = square_wave_rate;
			end
			chk("sqw_edges", 1, n >= 3 && n <= 5);
			i_rtcs_host.wr(5'h13, 8'h00);
			repeat (10) @(posedge clk);
			for (i = 0; i < 4000; i = i + 1)
				@(posedge clk) #1 if (square_wave_rate !== 1'b0) n = 99;
			chk("sqw_static", 1, n != 99);
			i_rtcs_host.wr(5'h08, 8'h00);
			repeat (2) @(posedge clk);
			#1 chk("pin_level_low", 1, irq_oe);
			i_rtcs_host.wr(5'h08, 8'h80);
			repeat (2) @(posedge clk);
			#1 chk("pin_level_high", 0, irq_oe);
			$display("test watchdog and square wave done");
		end
	endtask
	task rst_pulse(input two, input integer len, input exp);
		begin
			@(posedge clk) if (two) rin2 <= 1'b0; else rin1 <= 1'b0;
			repeat (len) @(posedge clk);
			rin1 <= 1'b1;
			rin2 <= 1'b1;
			repeat (4) @(posedge clk);
			#1 chk("rst_out", exp, rst_oe);
		end
	endtask
	task t_rst;
		begin
			rst_pulse(0, 10, 0);
			rst_pulse(0, 40, 1);
			repeat (30) @(posedge clk);
			#1 chk("rst_held", 1, rst_oe);
			repeat (20) @(posedge clk);
			#1 chk("rst_freed", 0, rst_oe);
			rst_pulse(1, 10, 0);
			rst_pulse(1, 45, 1);
			repeat (60) @(posedge clk) tr <= 1'b1;
			rst_pulse(0, 40, 1);
			repeat (25) @(posedge clk);
			#1 chk("rst_short", 0, rst_oe);
			@(posedge clk) begin
				tr <= 1'b0;
				st <= 1'b1;
			end
			rst_pulse(0, 40, 1);
			repeat (42) @(posedge clk);
			#1 chk("rst_long", 1, rst_oe);
			repeat (10) @(posedge clk);
			#1 chk("rst_long_end", 0, rst_oe);
			@(posedge clk) vcc_ok <= 1'b0;
			repeat (8) @(posedge clk);
			#1 chk("rst_vcc", 1, rst_oe);
			@(posedge clk) vcc_ok <= 1'b1;
			$display("test reset output done");
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (70) @(posedge clk);
		#1 chk("rst_powerup", 0, rst_oe);
		t_regs;
		t_modes;
		t_defer_batt;
		t_wdog_sqw;
		t_rst;
		report_and_stop;
	end
endmodule // rtcs_supervisor_tb_top
